// file: fsf_core.sv
// fsf_core.sv: fault supervision, flag registers, serial register access
// assumes: fault pins asynchronous; watchdog and mode inputs on i_clk
`timescale 1ns/1ps
`default_nettype none
`include "fsf_defines.svh"

// Notes on behaviour
// - in normal mode long-dominant transmit input disables driver, sets flags
// - over-temperature outside sleep disables driver and sets flags quickly
// - over-temperature moves device to fail-safe or thermal-protected mode
// - battery undervoltage sets flags, enters configured response mode
// - io undervoltage sets flags, pulls interrupt low, enters chosen mode
// - core supply undervoltage sets flags, enters configured response mode
// - watchdog errors counted; beyond limit act, flag, raise interrupt
// - clock edges per frame counted and checked after deselect
// - frame with wrong clock count discards its write
// - scratch register returns last value written, no side effects
module fsf_core
  import fsf_pkg::*;
#(
  parameter int unsigned TXD_TO_CYC  = `FSF_TXD_TO_CYC,
  parameter int unsigned UV_SLOW_CYC = `FSF_UV_SLOW_CYC,
  parameter int unsigned TSD_CYC     = `FSF_TSD_CYC,
  parameter int unsigned BATTERY_UNDERVOLTAGE_CYC   = `FSF_BATTERY_UNDERVOLTAGE_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_ce,
  input  wire logic       i_sclk,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_sdi,
  output logic            o_sdo,
  output logic            o_sdo_oe_n,
  input  wire logic       i_txd,
  input  wire logic       i_over_temp,
  input  wire logic       i_uv_sup,
  input  wire logic       i_uv_io,
  input  wire logic       i_uv_cc,
  input  wire logic       i_wd_violation,
  input  wire logic [7:0] i_wd_limit,
  input  wire fsf_resp_t  i_wd_resp,
  input  wire fsf_resp_t  i_sup_resp,
  input  wire fsf_resp_t  i_cc_resp,
  input  wire fsf_resp_t  i_io_resp,
  input  wire logic       i_tsd_failsafe,
  input  wire fsf_mode_t  i_prog_mode,
  input  wire logic       i_mode_req_vld,
  input  wire fsf_mode_t  i_mode_req,
  output fsf_mode_t       o_mode,
  output logic            o_can_tx_disable,
  output logic            o_interrupt_out_n
);

  // ----------------------------------------------------------------------
  // parameter checks and filter limits
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_MAX = (1 << `FSF_CNT_W) - 1;

  if (TXD_TO_CYC < 2 || TXD_TO_CYC > CNT_MAX ||
      UV_SLOW_CYC < 2 || UV_SLOW_CYC > CNT_MAX ||
      TSD_CYC < 2 || TSD_CYC > CNT_MAX ||
      BATTERY_UNDERVOLTAGE_CYC < 2 || BATTERY_UNDERVOLTAGE_CYC > CNT_MAX) begin : g_bad_param
    $error("fsf_core: filter count out of range");
  end

  localparam logic [4:0][`FSF_CNT_W-1:0] LIM = {
    `FSF_CNT_W'(UV_SLOW_CYC),
    `FSF_CNT_W'(UV_SLOW_CYC),
    `FSF_CNT_W'(BATTERY_UNDERVOLTAGE_CYC),
    `FSF_CNT_W'(TSD_CYC),
    `FSF_CNT_W'(TXD_TO_CYC)
  };

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [`FSF_CNT_W-1:0] sat_inc(
    input logic [`FSF_CNT_W-1:0] v
  );
    return (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  function automatic fsf_mode_t resp_mode(
    input fsf_resp_t r,
    input fsf_mode_t alt,
    input fsf_mode_t prog
  );
    fsf_mode_t m;
    m = FSF_MODE_FAILSAFE;
    unique case (r)
      FSF_RESP_PROG:     m = prog;
      FSF_RESP_ALT:      m = alt;
      FSF_RESP_FAILSAFE: m = FSF_MODE_FAILSAFE;
      default:           m = FSF_MODE_FAILSAFE;
    endcase
    return m;
  endfunction : resp_mode

  function automatic logic [7:0] rd_mux(
    input logic [6:0]   a,
    input fsf_core_st_t s
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `FSF_ADDR_SCRATCH: v = s.scratch;
      `FSF_ADDR_GLOBAL: begin
        v[`FSF_GLB_BUS] = |s.bus_flg;
        v[`FSF_GLB_SUP] = |s.sup_flg;
        v[`FSF_GLB_LNK] = |s.lnk_flg;
        v[`FSF_GLB_INT] = |{s.bus_flg, s.sup_flg, s.lnk_flg};
      end
      `FSF_ADDR_BUS:     v = s.bus_flg;
      `FSF_ADDR_SUP:     v = s.sup_flg;
      `FSF_ADDR_LNK:     v = s.lnk_flg;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction : rd_mux

  // ----------------------------------------------------------------------
  // serial link on the serial clock
  // ----------------------------------------------------------------------
  fsf_core_st_t q;
  fsf_core_st_t d;
  fsf_frame_t   frame;
  logic [4:0]   act;
  logic [4:0]   fault_on;
  logic         eval;
  logic         frame_ok;
  logic         wr_en;
  logic [6:0]   wr_addr;
  logic [7:0]   wr_data;

  fsf_spi_link u_link (
    .i_rst_b         (i_rst_b),
    .i_sclk          (i_sclk),
    .i_chip_select_n (i_chip_select_n),
    .i_sdi           (i_sdi),
    .i_rd_data       (q.rd_hold),
    .o_frame         (frame),
    .o_sdo           (o_sdo),
    .o_sdo_oe_n      (o_sdo_oe_n)
  );

  assign wr_addr = frame.word[14:8];
  assign wr_data = frame.word[7:0];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    d        = q;
    act      = 5'h00;
    fault_on = 5'h00;

    // pin synchronisers, transmit input dominant when low
    d.pin_m   = {i_uv_cc, i_uv_io, i_uv_sup, i_over_temp, ~i_txd};
    d.pin_s   = q.pin_m;
    d.cs_sync = {q.cs_sync[1:0], i_chip_select_n};

    // fault filters
    act = q.pin_s & {{4{q.mode != FSF_MODE_SLEEP}},
                     q.mode == FSF_MODE_NORMAL};
    for (int i = 0; i < 5; i++) begin
      if (!act[i]) begin
        d.cnt[i] = '0;
        d.hit[i] = 1'b0;
      end else if (q.cnt[i] >= LIM[i] - 1'b1) begin
        d.hit[i] = 1'b1;
      end else begin
        d.cnt[i] = sat_inc(q.cnt[i]);
      end
    end
    fault_on = d.hit & ~q.hit;

    // serial frame check once deselect is seen
    eval     = i_ce & q.cs_sync[1] & ~q.cs_sync[2];
    frame_ok = (frame.bits == `FSF_FRAME_BITS) &&
               (frame.tgl != q.frm_tgl);
    wr_en    = eval & frame_ok & frame.word[`FSF_WR_BIT];
    if (eval) begin
      d.rd_hold = rd_mux(wr_addr, q);
      d.frm_tgl = frame.tgl;
    end

    // register writes; flags clear on writing one
    if (wr_en) begin
      unique case (wr_addr)
        `FSF_ADDR_SCRATCH: d.scratch = wr_data;
        `FSF_ADDR_BUS:     d.bus_flg = q.bus_flg & ~wr_data;
        `FSF_ADDR_SUP:     d.sup_flg = q.sup_flg & ~wr_data;
        `FSF_ADDR_LNK: begin
          d.lnk_flg = q.lnk_flg & ~wr_data;
          if (wr_data[`FSF_LNK_WD]) begin
            d.wd_cnt = 8'h00;
          end
        end
        default: ;
      endcase
    end

    // host or system mode request
    if (i_mode_req_vld) begin
      d.mode = i_mode_req;
    end

    // serial error flag, set wins over clear
    if (eval && !frame_ok) begin
      d.lnk_flg[`FSF_LNK_SPI] = 1'b1;
    end

    // watchdog error counting
    if (i_wd_violation) begin
      d.wd_cnt = (&d.wd_cnt) ? d.wd_cnt : d.wd_cnt + 8'h01;
      if (d.wd_cnt > i_wd_limit && !d.lnk_flg[`FSF_LNK_WD]) begin
        d.lnk_flg[`FSF_LNK_WD] = 1'b1;
        d.mode = resp_mode(i_wd_resp, FSF_MODE_RESTART, i_prog_mode);
      end
    end

    // transmit dominant timeout
    if (fault_on[`FSF_FLT_TXD]) begin
      d.bus_flg[`FSF_BUS_TXD] = 1'b1;
    end

    // supply undervoltage, lowest priority first
    if (fault_on[`FSF_FLT_IO_SUPPLY_UNDERVOLTAGE]) begin
      d.sup_flg[`FSF_SUP_IO_SUPPLY_UNDERVOLTAGE] = 1'b1;
      d.mode = resp_mode(i_io_resp, FSF_MODE_IO_SUPPLY_UNDERVOLTAGE_PROT, i_prog_mode);
    end
    if (fault_on[`FSF_FLT_CORE_SUPPLY_UNDERVOLTAGE]) begin
      d.sup_flg[`FSF_SUP_CORE_SUPPLY_UNDERVOLTAGE] = 1'b1;
      d.mode = resp_mode(i_cc_resp, FSF_MODE_SLEEP, i_prog_mode);
    end
    if (fault_on[`FSF_FLT_BATTERY_UNDERVOLTAGE]) begin
      d.sup_flg[`FSF_SUP_BATTERY_UNDERVOLTAGE] = 1'b1;
      d.mode = resp_mode(i_sup_resp, FSF_MODE_SLEEP, i_prog_mode);
    end

    // over-temperature has the last word
    if (fault_on[`FSF_FLT_TSD]) begin
      d.sup_flg[`FSF_SUP_TSD] = 1'b1;
      d.mode = i_tsd_failsafe ? FSF_MODE_FAILSAFE
                              : FSF_MODE_TSD_PROT;
    end

    // driver disable
    d.tx_dis = d.hit[`FSF_FLT_TXD] | d.hit[`FSF_FLT_TSD] |
               (d.mode == FSF_MODE_FAILSAFE) |
               (d.mode == FSF_MODE_TSD_PROT) |
               (d.mode == FSF_MODE_SLEEP);

    // interrupt pin follows the global bit
    d.int_n = ~|{d.bus_flg, d.sup_flg, d.lnk_flg};
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q         <= '0;
      q.cs_sync <= 3'h7;
      q.scratch <= `FSF_RST_REG;
      q.bus_flg <= `FSF_RST_REG;
      q.sup_flg <= `FSF_RST_REG;
      q.lnk_flg <= `FSF_RST_REG;
      q.mode    <= FSF_MODE_NORMAL;
      q.int_n   <= 1'b1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_mode            = q.mode;
  assign o_can_tx_disable  = q.tx_dis;
  assign o_interrupt_out_n = q.int_n;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  txd_timeout_a: assert property ($rose(q.hit[`FSF_FLT_TXD]) |->
      q.bus_flg[`FSF_BUS_TXD] && o_can_tx_disable)
    else $error("stuck transmit not flagged");

  tsd_flag_a: assert property ($rose(q.hit[`FSF_FLT_TSD]) |->
      q.sup_flg[`FSF_SUP_TSD] && o_can_tx_disable && !o_interrupt_out_n)
    else $error("over-temperature not flagged");

  tsd_mode_a: assert property ($rose(q.hit[`FSF_FLT_TSD]) |->
      (o_mode == FSF_MODE_FAILSAFE) == $past(i_tsd_failsafe) &&
      (o_mode inside {FSF_MODE_FAILSAFE, FSF_MODE_TSD_PROT}))
    else $error("over-temperature mode wrong");

  battery_undervoltage_flag_a: assert property ($rose(q.hit[`FSF_FLT_BATTERY_UNDERVOLTAGE]) |->
      q.sup_flg[`FSF_SUP_BATTERY_UNDERVOLTAGE] && o_mode != FSF_MODE_NORMAL ||
      q.sup_flg[`FSF_SUP_BATTERY_UNDERVOLTAGE] && $past(i_sup_resp) == FSF_RESP_PROG)
    else $error("battery undervoltage not handled");

  io_supply_undervoltage_flag_a: assert property ($rose(q.hit[`FSF_FLT_IO_SUPPLY_UNDERVOLTAGE]) |->
      q.sup_flg[`FSF_SUP_IO_SUPPLY_UNDERVOLTAGE] && !o_interrupt_out_n)
    else $error("io undervoltage not flagged");

  core_supply_undervoltage_flag_a: assert property ($rose(q.hit[`FSF_FLT_CORE_SUPPLY_UNDERVOLTAGE]) |->
      q.sup_flg[`FSF_SUP_CORE_SUPPLY_UNDERVOLTAGE])
    else $error("core undervoltage not flagged");

  wd_limit_a: assert property (i_ce && i_wd_violation &&
      !q.lnk_flg[`FSF_LNK_WD] && q.wd_cnt >= i_wd_limit &&
      q.wd_cnt != 8'hff |=> q.lnk_flg[`FSF_LNK_WD] ##1 !o_interrupt_out_n)
    else $error("watchdog limit not acted on");

  bad_frame_a: assert property (eval && !frame_ok |=>
      q.lnk_flg[`FSF_LNK_SPI] && $stable(q.scratch) &&
      (($past(q.bus_flg) & ~q.bus_flg) == 8'h00))
    else $error("bad frame not refused");

  scratch_wr_a: assert property (wr_en &&
      wr_addr == `FSF_ADDR_SCRATCH |=> q.scratch == $past(wr_data))
    else $error("scratch write lost");

  int_pin_a: assert property (|{q.bus_flg, q.sup_flg, q.lnk_flg}
      == !o_interrupt_out_n)
    else $error("interrupt pin disagrees with flags");

  scratch_wr_c: cover property (wr_en && wr_addr == `FSF_ADDR_SCRATCH);
  bad_frame_c:  cover property (eval && !frame_ok);
  tsd_entry_c:  cover property ($rose(q.hit[`FSF_FLT_TSD]));
  wd_act_c:     cover property ($rose(q.lnk_flg[`FSF_LNK_WD]));

endmodule : fsf_core

`default_nettype wire

// file: fsf_defines.svh
// fsf_defines.svh: offsets, field positions, reset values, timing counts
// assumes: core clock of 40 MHz; included by bare name
`ifndef FSF_DEFINES_SVH
`define FSF_DEFINES_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FSF_CLK_PERIOD_NS 25
`define FSF_TXD_TO_NS     3500000
`define FSF_TSD_NS        4400
`define FSF_BATTERY_UNDERVOLTAGE_NS      2200
`define FSF_UV_SLOW_NS    330000000
`define FSF_TXD_TO_CYC ((`FSF_TXD_TO_NS+`FSF_CLK_PERIOD_NS-1)/`FSF_CLK_PERIOD_NS)
`define FSF_TSD_CYC     (`FSF_TSD_NS / `FSF_CLK_PERIOD_NS)
`define FSF_BATTERY_UNDERVOLTAGE_CYC   (`FSF_BATTERY_UNDERVOLTAGE_NS / `FSF_CLK_PERIOD_NS)
`define FSF_UV_SLOW_CYC (`FSF_UV_SLOW_NS / `FSF_CLK_PERIOD_NS)
`define FSF_CNT_W       24

// ----------------------------------------------------------------------
// serial frame
// ----------------------------------------------------------------------
`define FSF_FRAME_BITS 5'h10
`define FSF_WR_BIT     15

// ----------------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------------
`define FSF_ADDR_SCRATCH 7'h0f
`define FSF_ADDR_GLOBAL  7'h50
`define FSF_ADDR_BUS     7'h51
`define FSF_ADDR_SUP     7'h52
`define FSF_ADDR_LNK     7'h53
`define FSF_GLB_INT   7
`define FSF_GLB_BUS   6
`define FSF_GLB_SUP   5
`define FSF_GLB_LNK   4
`define FSF_BUS_TXD   0
`define FSF_SUP_TSD   1
`define FSF_SUP_CORE_SUPPLY_UNDERVOLTAGE  2
`define FSF_SUP_IO_SUPPLY_UNDERVOLTAGE  3
`define FSF_SUP_BATTERY_UNDERVOLTAGE 4
`define FSF_LNK_WD    6
`define FSF_LNK_SPI   7
`define FSF_RST_REG   8'h00

// fault filter index
`define FSF_FLT_TXD   0
`define FSF_FLT_TSD   1
`define FSF_FLT_BATTERY_UNDERVOLTAGE 2
`define FSF_FLT_IO_SUPPLY_UNDERVOLTAGE  3
`define FSF_FLT_CORE_SUPPLY_UNDERVOLTAGE  4

`endif

// file: fsf_pkg.sv
// fsf_pkg.sv: types of the fault supervisor
// assumes: fsf_defines.svh on the include path
`include "fsf_defines.svh"

package fsf_pkg;

  typedef enum logic [2:0] {
    FSF_MODE_NORMAL    = 3'h0,
    FSF_MODE_STANDBY   = 3'h1,
    FSF_MODE_SLEEP     = 3'h2,
    FSF_MODE_FAILSAFE  = 3'h3,
    FSF_MODE_TSD_PROT  = 3'h4,
    FSF_MODE_IO_SUPPLY_UNDERVOLTAGE_PROT = 3'h5,
    FSF_MODE_RESTART   = 3'h6
  } fsf_mode_t;

  typedef enum logic [1:0] {
    FSF_RESP_PROG     = 2'h0,
    FSF_RESP_ALT      = 2'h1,
    FSF_RESP_FAILSAFE = 2'h2
  } fsf_resp_t;

  typedef struct packed {
    logic        tgl;
    logic [4:0]  bits;
    logic [15:0] word;
  } fsf_frame_t;

  typedef struct packed {
    logic [7:0] out;
    fsf_frame_t frm;
  } fsf_link_st_t;

  typedef struct packed {
    logic [2:0]                  cs_sync;
    logic [4:0]                  pin_m;
    logic [4:0]                  pin_s;
    logic [4:0][`FSF_CNT_W-1:0]  cnt;
    logic [4:0]                  hit;
    logic [7:0]                  scratch;
    logic [7:0]                  bus_flg;
    logic [7:0]                  sup_flg;
    logic [7:0]                  lnk_flg;
    logic [7:0]                  rd_hold;
    logic [7:0]                  wd_cnt;
    logic                        frm_tgl;
    fsf_mode_t                   mode;
    logic                        tx_dis;
    logic                        int_n;
  } fsf_core_st_t;

endpackage : fsf_pkg

// file: fsf_spi_link.sv
// fsf_spi_link.sv: serial shifter on the serial clock
// assumes: mode 0 frames, msb first; i_rd_data static while selected
`timescale 1ns/1ps
`default_nettype none

module fsf_spi_link
  import fsf_pkg::*;
(
  input  wire logic       i_rst_b,
  input  wire logic       i_sclk,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_sdi,
  input  wire logic [7:0] i_rd_data,
  output var fsf_frame_t  o_frame,
  output logic            o_sdo,
  output logic            o_sdo_oe_n
);

  fsf_link_st_t q;
  fsf_link_st_t d;
  logic         first_q;

  // ----------------------------------------------------------------------
  // frame start marker, preset while deselected
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sclk or posedge i_chip_select_n or negedge i_rst_b)
  begin
    if (!i_rst_b) begin
      first_q <= 1'b1;
    end else if (i_chip_select_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // shift and count
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    if (first_q) begin
      d.frm.tgl  = ~q.frm.tgl;
      d.frm.bits = 5'h01;
      d.frm.word = {15'h0000, i_sdi};
      d.out      = {i_rd_data[6:0], 1'b0};
    end else begin
      d.frm.bits = (&q.frm.bits) ? q.frm.bits : q.frm.bits + 5'h01;
      d.frm.word = {q.frm.word[14:0], i_sdi};
      d.out      = {q.out[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_sclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_frame    = q.frm;
  assign o_sdo      = first_q ? i_rd_data[7] : q.out[7];
  assign o_sdo_oe_n = i_chip_select_n;

endmodule : fsf_spi_link

`default_nettype wire

// file: fsf_host_model.sv
// fsf_host_model.sv: host microcontroller on the serial control port
// assumes: 16-bit mode 0 frames, msb first, 80 ns serial clock
`timescale 1ns/1ps
`default_nettype none
`include "fsf_defines.svh"

module fsf_host_model (
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe_n,
  output logic      o_sclk,
  output logic      o_chip_select_n,
  output logic      o_sdi
);
  // ------
  // idle levels: clock low, select and data pulled up
  // ------
  initial begin
    o_sclk          = 1'b0;
    o_chip_select_n = 1'b1;
    o_sdi           = 1'b1;
  end

  // ------
  // one frame of nbits clocks; first sdo byte returned
  // ------
  task automatic frame(input logic [15:0] word, input int nbits,
                       output logic [7:0] rd);
    logic [31:0] sh;
    sh = {word, 16'hffff};
    rd = 8'h00;
    #13;
    o_chip_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_sdi = sh[31-i];
      #40;
      if (i < 8) rd = {rd[6:0], (i_sdo_oe_n === 1'b0) ? i_sdo : 1'bx};
      o_sclk = 1'b1;
      #40;
      o_sclk = 1'b0;
    end
    #40;
    o_chip_select_n = 1'b1;
    o_sdi           = 1'b1;
    #200;
  endtask : frame

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] nc;
    frame({1'b1, a, d}, 16, nc);
  endtask : wr

  // read needs a second frame to carry the data out
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] nc;
    frame({1'b0, a, 8'h00}, 16, nc);
    frame({1'b0, `FSF_ADDR_SCRATCH, 8'h00}, 16, d);
  endtask : rd
endmodule : fsf_host_model
`default_nettype wire

// file: tb_fault_supervisor_flags.sv
// tb_fault_supervisor_flags.sv: self-checking bench of fsf_core
// assumes: fsf_host_model drives the serial port
`timescale 1ns/1ps
`default_nettype none
`include "fsf_defines.svh"

module tb_fault_supervisor_flags;
  import fsf_pkg::*;
  localparam int TXD_C = 50;
  localparam int UVS_C = 40;
  localparam int TSD_C = 20;
  localparam int SUP_C = 12;
  logic       clk, rst_b, txd, wd_v, mreq_v, tsd_fs;
  logic       sclk, csn, sdi, sdo, sdo_oe_n, tx_dis, int_n;
  logic [3:0] flt;
  logic [7:0] wd_lim, r, d;
  logic [6:0] regs [5] = '{`FSF_ADDR_SCRATCH, `FSF_ADDR_GLOBAL,
                           `FSF_ADDR_BUS, `FSF_ADDR_SUP, `FSF_ADDR_LNK};
  fsf_resp_t  wd_resp, sup_resp, cc_resp, io_resp;
  fsf_mode_t  prog, mreq, mode;
  int         errors, tests_run, seed, lim;

  fsf_core #(.TXD_TO_CYC(TXD_C), .UV_SLOW_CYC(UVS_C), .TSD_CYC(TSD_C),
             .BATTERY_UNDERVOLTAGE_CYC(SUP_C)) DUT (
    .i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_sclk(sclk),
    .i_chip_select_n(csn), .i_sdi(sdi), .o_sdo(sdo),
    .o_sdo_oe_n(sdo_oe_n), .i_txd(txd), .i_over_temp(flt[0]),
    .i_uv_sup(flt[1]), .i_uv_io(flt[2]), .i_uv_cc(flt[3]),
    .i_wd_violation(wd_v), .i_wd_limit(wd_lim), .i_wd_resp(wd_resp),
    .i_sup_resp(sup_resp), .i_cc_resp(cc_resp), .i_io_resp(io_resp),
    .i_tsd_failsafe(tsd_fs), .i_prog_mode(prog),
    .i_mode_req_vld(mreq_v), .i_mode_req(mreq), .o_mode(mode),
    .o_can_tx_disable(tx_dis), .o_interrupt_out_n(int_n));

  fsf_host_model host (.i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n), .o_sclk(sclk),
                       .o_chip_select_n(csn), .o_sdi(sdi));

  // ------
  // clock, checks, verdict
  // ------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : do_reset

  function automatic fsf_mode_t exp_mode(fsf_resp_t rs, fsf_mode_t alt);
    case (rs)
      FSF_RESP_PROG: return prog;
      FSF_RESP_ALT:  return alt;
      default:       return FSF_MODE_FAILSAFE;
    endcase
  endfunction : exp_mode

  function automatic logic exp_txdis(fsf_mode_t m, int idx);
    return (idx <= 1) || (m inside {FSF_MODE_SLEEP, FSF_MODE_FAILSAFE,
                                    FSF_MODE_TSD_PROT});
  endfunction : exp_txdis

  // ------
  // fault pin held until flagged, then cleared by the host
  // ------
  task automatic run_fault(input int idx, input int lm, input fsf_mode_t em,
                           input logic [6:0] a, input logic [7:0] ef);
    int n;
    n = 0;
    @(posedge clk);
    if (idx == 0) txd <= 1'b0;
    else flt[idx-1] <= 1'b1;
    while (int_n !== 1'b0 && n < lm + 10) begin
      @(negedge clk);
      n++;
    end
    chk(8'((n > lm) && (n <= lm + 5)), 8'h01, "latency");
    chk({5'h0, mode}, {5'h0, em}, "mode");
    chk({7'h0, tx_dis}, {7'h0, exp_txdis(em, idx)}, "tx off");
    host.rd(a, r);
    chk(r, ef, "flag");
    host.rd(`FSF_ADDR_GLOBAL, r);
    chk(r, (idx == 0) ? 8'hc0 : 8'ha0, "summary");
    @(posedge clk);
    if (idx == 0) txd <= 1'b1;
    else flt[idx-1] <= 1'b0;
    repeat (4) @(negedge clk);
    if (idx == 0) chk({7'h0, tx_dis}, 8'h00, "tx back");
    chk({7'h0, int_n}, 8'h00, "int held");
    host.wr(a, ef);
    host.rd(a, r);
    chk(r, 8'h00, "flag clear");
    chk({7'h0, int_n}, 8'h01, "int released");
  endtask : run_fault

  // ------
  // main sequence
  // ------
  initial begin
    errors = 0;
    tests_run = 0;
    seed = 32'hbd047d34;
    rst_b    = 1'b0;
    txd      = 1'b1;
    flt      = 4'h0;
    wd_v     = 1'b0;
    mreq_v   = 1'b0;
    tsd_fs   = 1'b0;
    wd_lim   = 8'h00;
    wd_resp  = FSF_RESP_PROG;
    sup_resp = FSF_RESP_PROG;
    cc_resp  = FSF_RESP_PROG;
    io_resp  = FSF_RESP_PROG;
    mreq = FSF_MODE_NORMAL;
    prog = ($random(seed) & 1) ? FSF_MODE_STANDBY : FSF_MODE_NORMAL;
    do_reset();
    chk({3'h0, mode, tx_dis, int_n}, 8'h01, "reset pins");
    foreach (regs[i]) begin
      host.rd(regs[i], r);
      chk(r, `FSF_RST_REG, "reset reg");
    end
    repeat (4) begin
      d = 8'($random(seed));
      host.wr(`FSF_ADDR_SCRATCH, d);
      host.wr(`FSF_ADDR_GLOBAL, ~d);
      host.rd(`FSF_ADDR_SCRATCH, r);
      chk(r, d, "scratch");
    end
    host.rd(7'h20, r);
    chk(r, 8'h00, "unmapped");
    $display("test scratch done");
    foreach (regs[i]) begin
      host.frame({1'b1, `FSF_ADDR_SCRATCH, ~d}, (i % 3) * 17 - 2 * i, r);
      host.rd(`FSF_ADDR_SCRATCH, r);
      chk(r, d, "bad frame write");
      host.rd(`FSF_ADDR_LNK, r);
      chk(r, 8'h80, "frame flag");
      host.rd(`FSF_ADDR_GLOBAL, r);
      chk(r, 8'h90, "frame summary");
      chk({7'h0, int_n}, 8'h00, "frame int");
      host.wr(`FSF_ADDR_LNK, 8'h80);
      chk({7'h0, int_n}, 8'h01, "frame int off");
    end
    $display("test frames done");
    do_reset();
    run_fault(0, TXD_C, FSF_MODE_NORMAL, `FSF_ADDR_BUS, 8'h01);
    for (int k = 0; k < 2; k++) begin
      tsd_fs = k[0];
      do_reset();
      run_fault(1, TSD_C, k ? FSF_MODE_FAILSAFE : FSF_MODE_TSD_PROT,
                `FSF_ADDR_SUP, 8'h02);
    end
    for (int k = 0; k < 3; k++) begin
      sup_resp = fsf_resp_t'(k);
      io_resp  = fsf_resp_t'(k);
      cc_resp  = fsf_resp_t'(k);
      do_reset();
      run_fault(2, SUP_C, exp_mode(sup_resp, FSF_MODE_SLEEP),
                `FSF_ADDR_SUP, 8'h10);
      do_reset();
      run_fault(3, UVS_C, exp_mode(io_resp, FSF_MODE_IO_SUPPLY_UNDERVOLTAGE_PROT),
                `FSF_ADDR_SUP, 8'h08);
      do_reset();
      run_fault(4, UVS_C, exp_mode(cc_resp, FSF_MODE_SLEEP),
                `FSF_ADDR_SUP, 8'h04);
    end
    $display("test faults done");
    for (int k = 0; k < 3; k++) begin
      wd_resp = fsf_resp_t'(k);
      lim = ($random(seed) & 3) + 1;
      wd_lim = 8'(lim);
      do_reset();
      for (int p = 0; p <= lim; p++) begin
        chk({7'h0, int_n}, 8'h01, "wd below limit");
        @(posedge clk);
        wd_v <= 1'b1;
        @(posedge clk);
        wd_v <= 1'b0;
        @(negedge clk);
      end
      chk({7'h0, int_n}, 8'h00, "wd int");
      chk({5'h0, mode}, {5'h0, exp_mode(wd_resp, FSF_MODE_RESTART)},
          "wd mode");
      host.rd(`FSF_ADDR_LNK, r);
      chk(r, 8'h40, "wd flag");
    end
    $display("test watchdog done");
    do_reset();
    @(posedge clk);
    mreq   <= FSF_MODE_SLEEP;
    mreq_v <= 1'b1;
    @(posedge clk);
    mreq_v <= 1'b0;
    flt    <= 4'h3;
    repeat (3 * TSD_C) @(negedge clk);
    chk({4'h0, mode, int_n}, {4'h0, FSF_MODE_SLEEP, 1'b1}, "sleep");
    $display("test sleep done");
    summarize();
  end

  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule : tb_fault_supervisor_flags
`default_nettype wire
